// ### eebac_pkg.sv
// constants, register map and state type of the nonvolatile byte access controller
package eebac_pkg;
    // i/o space offsets
    localparam logic [5:0] OFS_ADDR_LOW = 6'h1E;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h1F;
    localparam logic [5:0] OFS_DATA = 6'h1D;
    localparam logic [5:0] OFS_CONTROL = 6'h1C;
    // control register bit positions
    localparam int CTL_READY_IRQ_EN = 3;
    localparam int CTL_MASTER_ARM = 2;
    localparam int CTL_WRITE_STROBE = 1;
    localparam int CTL_READ_STROBE = 0;
    // array geometry
    localparam int ADDR_BITS = 11;
    localparam int ARRAY_BYTES = 2048;
    // values after reset
    localparam logic [10:0] ADDR_RESET = 11'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // cpu clock cycles
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
    localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
    localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;
    // timing oscillator
    localparam longint CLK_FREQ_HZ = 200000000;
    localparam longint OSC_FREQ_HZ = 1000000;
    localparam int OSC_DIV_CYCLES = int'(CLK_FREQ_HZ / OSC_FREQ_HZ);
    localparam int WRITE_TIME_OSC_CYCLES = 8448;
    // write engine states
    typedef enum logic {
        EEBAC_ENG_IDLE,
        EEBAC_ENG_PROG
    } eebac_eng_e;
endpackage

// ### eebac_top.sv
// nonvolatile byte access controller: i/o registers, stalls, guarded self-timed write
// Behaviour
// - a read stalls the processor four clock cycles.
// - starting a write stalls the processor two clock cycles.
// - address is 11 bits over two registers; upper five high bits read zero.
// - address selects bytes linearly in the 2K array; software loads it first.
// - data register supplies write byte and receives read byte.
// - control bits 7..4 always read zero.
// - ready irq enable with global enable requests irq while not busy.
// - master write arm clears itself four clock cycles after being set.
// - write strobe starts a write only while master arm is set.
// - write strobe stays set during programming, cleared by hardware at end.
// - a write lasts 8448 cycles of the 1 MHz timing oscillator.
// - access timing comes from the timing oscillator, not the cpu clock; here the oscillator tick is CORE_CLK divided by OSC_DIV.
// - no array programming while flash is being written; software waits.
// - read strobe makes the addressed byte available at once.
// - during a write, reads are ignored and address changes blocked.
// - a write in progress continues in power-down; oscillator runs until done.
// - a write in progress completes across a device reset.
`timescale 1ns/100ps
module eebac_top #(
    parameter int WRITE_TICKS = eebac_pkg::WRITE_TIME_OSC_CYCLES,
    parameter int OSC_DIV = eebac_pkg::OSC_DIV_CYCLES
) (
    // clock and resets
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PWR_ARST_N,
    // cpu i/o access
    input wire logic [5:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WE,
    input wire logic IO_RE,
    output logic [7:0] IO_RDATA,
    output logic CPU_STALL,
    // interrupt
    input wire logic GLOBAL_IRQ_EN,
    output logic EE_READY_IRQ,
    // system status
    input wire logic FLASH_PROG_BUSY,
    input wire logic POWER_DOWN,
    output logic OSC_RUN_REQ
);
    if (WRITE_TICKS < 2 || WRITE_TICKS > 16383) begin : g_chk_ticks
        $error("WRITE_TICKS out of range");
    end
    if (OSC_DIV < 1 || OSC_DIV > 65535) begin : g_chk_div
        $error("OSC_DIV out of range");
    end

    localparam logic [13:0] TICKS = 14'(WRITE_TICKS);
    localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

    logic [7:0] mem [0:eebac_pkg::ARRAY_BYTES-1];

    logic [10:0] addr_reg;
    logic [7:0] data_reg;
    logic rie_reg;
    logic arm_reg;
    logic [2:0] arm_cnt_reg;
    logic [2:0] stall_cnt_reg;
    logic [2:0] stall_cnt_next;
    logic stall_reg;
    logic [7:0] rdata_reg;
    logic irq_reg;
    eebac_pkg::eebac_eng_e eng_reg;
    logic [13:0] tick_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic tick_reg;
    logic [10:0] eng_addr_reg;
    logic [7:0] eng_data_reg;
    logic osc_run_reg;

    // decode
    wire busy = (eng_reg == eebac_pkg::EEBAC_ENG_PROG);
    wire we_low = IO_WE && (IO_ADDR == eebac_pkg::OFS_ADDR_LOW);
    wire we_high = IO_WE && (IO_ADDR == eebac_pkg::OFS_ADDR_HIGH);
    wire we_data = IO_WE && (IO_ADDR == eebac_pkg::OFS_DATA);
    wire we_ctl = IO_WE && (IO_ADDR == eebac_pkg::OFS_CONTROL);
    wire set_arm = we_ctl && IO_WDATA[eebac_pkg::CTL_MASTER_ARM];
    wire read_go = we_ctl && IO_WDATA[eebac_pkg::CTL_READ_STROBE] && !busy;
    // arm is sampled before this access lands, so arm and strobe in one write start nothing unless arm was already set
    wire write_go = we_ctl && IO_WDATA[eebac_pkg::CTL_WRITE_STROBE] && arm_reg
        && !busy && !FLASH_PROG_BUSY;
    wire write_done = busy && tick_reg && (tick_cnt_reg == 14'h0001);
    wire [7:0] ctl_view = {4'h0, rie_reg, arm_reg, busy, 1'b0};
    wire [7:0] rdata_next = (IO_ADDR == eebac_pkg::OFS_ADDR_LOW) ? addr_reg[7:0] :
        (IO_ADDR == eebac_pkg::OFS_ADDR_HIGH) ? {5'h00, addr_reg[10:8]} :
        (IO_ADDR == eebac_pkg::OFS_DATA) ? data_reg :
        (IO_ADDR == eebac_pkg::OFS_CONTROL) ? ctl_view : 8'h00;
    wire osc_run_next = busy || write_go || !POWER_DOWN;

    assign stall_cnt_next = read_go ? eebac_pkg::READ_STALL_CYCLES :
        write_go ? eebac_pkg::WRITE_STALL_CYCLES :
        (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 3'h1 : 3'h0;

    // address: 11 linear bits, frozen while programming
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_reg <= eebac_pkg::ADDR_RESET;
        end else if (we_low && !busy) begin
            addr_reg[7:0] <= IO_WDATA;
        end else if (we_high && !busy) begin
            addr_reg[10:8] <= IO_WDATA[2:0];
        end
    end

    // data: cpu writes it, a read strobe loads it from the array in one access
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            data_reg <= eebac_pkg::DATA_RESET;
        end else if (read_go) begin
            data_reg <= mem[addr_reg];
        end else if (we_data) begin
            data_reg <= IO_WDATA;
        end
    end

    // control bits and master arm window
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rie_reg <= 1'b0;
            arm_reg <= 1'b0;
            arm_cnt_reg <= 3'h0;
        end else if (we_ctl) begin
            rie_reg <= IO_WDATA[eebac_pkg::CTL_READY_IRQ_EN];
            arm_reg <= set_arm;
            arm_cnt_reg <= set_arm ? eebac_pkg::ARM_WINDOW_CYCLES - 3'h1 : 3'h0;
        end else if (arm_reg) begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
            arm_reg <= (arm_cnt_reg != 3'h0);
        end
    end

    // cpu stall and read port
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stall_cnt_reg <= 3'h0;
            stall_reg <= 1'b0;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            stall_cnt_reg <= stall_cnt_next;
            stall_reg <= (stall_cnt_next != 3'h0);
            rdata_reg <= IO_RE ? rdata_next : rdata_reg;
            irq_reg <= rie_reg && GLOBAL_IRQ_EN && !busy;
        end
    end

    // timing oscillator as a divided enable; the engine sits on the power-on reset
    // so that a device reset does not cut a write short
    always_ff @(posedge CORE_CLK or negedge PWR_ARST_N) begin
        if (!PWR_ARST_N) begin
            div_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
            osc_run_reg <= 1'b1;
        end else begin
            osc_run_reg <= osc_run_next;
            if (!osc_run_next || div_cnt_reg == DIV_LAST) begin
                div_cnt_reg <= 16'h0000;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h0001;
            end
            tick_reg <= osc_run_next && (div_cnt_reg == DIV_LAST);
        end
    end

    // write engine
    always_ff @(posedge CORE_CLK or negedge PWR_ARST_N) begin
        if (!PWR_ARST_N) begin
            eng_reg <= eebac_pkg::EEBAC_ENG_IDLE;
            tick_cnt_reg <= 14'h0000;
            eng_addr_reg <= 11'h000;
            eng_data_reg <= 8'h00;
        end else begin
            case (eng_reg)
                eebac_pkg::EEBAC_ENG_IDLE: begin
                    if (write_go) begin
                        eng_reg <= eebac_pkg::EEBAC_ENG_PROG;
                        tick_cnt_reg <= TICKS;
                        eng_addr_reg <= addr_reg;
                        eng_data_reg <= data_reg;
                    end
                end
                eebac_pkg::EEBAC_ENG_PROG: begin
                    if (write_done) begin
                        eng_reg <= eebac_pkg::EEBAC_ENG_IDLE;
                    end else if (tick_reg) begin
                        tick_cnt_reg <= tick_cnt_reg - 14'h0001;
                    end
                end
                default: begin
                    eng_reg <= eebac_pkg::EEBAC_ENG_IDLE;
                end
            endcase
        end
    end

    // the array itself holds no reset
    always_ff @(posedge CORE_CLK) begin
        if (write_done) begin
            mem[eng_addr_reg] <= eng_data_reg;
        end
    end

    assign IO_RDATA = rdata_reg;
    assign CPU_STALL = stall_reg;
    assign EE_READY_IRQ = irq_reg;
    assign OSC_RUN_REQ = osc_run_reg;

    // write length watch: core cycles from the start edge to the last tick;
    // the free-running divider lets the first tick land anywhere in one period
    localparam logic [31:0] WR_CYC_MIN = 32'(OSC_DIV * (WRITE_TICKS - 1));
    localparam logic [31:0] WR_CYC_MAX = 32'(OSC_DIV * WRITE_TICKS - 1);
    logic [31:0] busy_cyc_reg;
    always_ff @(posedge CORE_CLK or negedge PWR_ARST_N) begin
        if (!PWR_ARST_N) begin
            busy_cyc_reg <= 32'h00000000;
        end else if (write_go) begin
            busy_cyc_reg <= 32'h00000000;
        end else if (busy) begin
            busy_cyc_reg <= busy_cyc_reg + 32'h00000001;
        end
    end

    // checks
    read_stall_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        read_go |=> CPU_STALL[*4] ##1 !CPU_STALL)
        else $error("read stall not four cycles");
    write_stall_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        write_go |=> CPU_STALL[*2] ##1 !CPU_STALL)
        else $error("write stall not two cycles");
    arm_window_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (set_arm ##1 (!we_ctl)[*4]) |-> arm_reg)
        else $error("master arm dropped early");
    arm_timeout_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (set_arm ##1 (!we_ctl)[*4]) |=> !arm_reg)
        else $error("master arm did not time out");
    strobe_guard_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N || !ARST_N)
        (!busy && !arm_reg) |=> !busy)
        else $error("write started without arm");
    flash_lock_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        (FLASH_PROG_BUSY && !busy) |=> !busy)
        else $error("write started during flash programming");
    busy_view_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N || !PWR_ARST_N)
        write_go |=> busy && (ctl_view[eebac_pkg::CTL_WRITE_STROBE] == 1'b1))
        else $error("write strobe not shown busy");
    addr_freeze_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (busy && we_low) |=> $stable(addr_reg))
        else $error("address changed while programming");
    read_block_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (busy && we_ctl && IO_WDATA[0] && !we_data) |=> $stable(data_reg))
        else $error("read accepted while programming");
    high_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (IO_RE && IO_ADDR == eebac_pkg::OFS_ADDR_HIGH) |=> (IO_RDATA[7:3] == 5'h00))
        else $error("upper address bits not zero");
    ctl_zero_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (IO_RE && IO_ADDR == eebac_pkg::OFS_CONTROL) |=> (IO_RDATA[7:4] == 4'h0))
        else $error("control upper bits not zero");
    ready_irq_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (rie_reg && GLOBAL_IRQ_EN && !busy) |=> EE_READY_IRQ)
        else $error("ready interrupt missing");
    irq_off_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (!rie_reg || !GLOBAL_IRQ_EN || busy) |=> !EE_READY_IRQ)
        else $error("ready interrupt raised while masked or busy");
    osc_keep_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        busy |=> OSC_RUN_REQ)
        else $error("oscillator stopped during write");
    tick_rate_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        (tick_reg && OSC_DIV > 1) |=> !tick_reg)
        else $error("timing tick too fast");
    write_len_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        write_done |-> ((busy_cyc_reg >= WR_CYC_MIN) && (busy_cyc_reg <= WR_CYC_MAX)))
        else $error("write time outside the tick window");
    stall_free_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (!read_go && !write_go && stall_cnt_reg == 3'h0) |=> !CPU_STALL)
        else $error("stall without an access");
    busy_end_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        write_done |=> !busy)
        else $error("write strobe not cleared at end of write");
    busy_hold_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        (busy && !write_done) |=> busy)
        else $error("write strobe cleared before end of write");
    osc_stop_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        (POWER_DOWN && !busy && !write_go) |=> !OSC_RUN_REQ)
        else $error("oscillator kept running in power-down");
    latch_a: assert property (@(posedge CORE_CLK) disable iff (!PWR_ARST_N)
        write_go |=> (eng_data_reg == $past(data_reg)) && (eng_addr_reg == $past(addr_reg)))
        else $error("write engine latched wrong address or data");
    data_hold_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (!read_go && !we_data) |=> $stable(data_reg))
        else $error("data register changed without an access");
    rie_view_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (IO_RE && IO_ADDR == eebac_pkg::OFS_CONTROL)
        |=> (IO_RDATA[eebac_pkg::CTL_READY_IRQ_EN] == $past(rie_reg)))
        else $error("ready irq enable read back wrong");
    addr_view_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (IO_RE && IO_ADDR == eebac_pkg::OFS_ADDR_HIGH) |=> (IO_RDATA[2:0] == $past(addr_reg[10:8])))
        else $error("high address bits read back wrong");
endmodule // eebac_top

// ### tb_top.sv
// self-checking testbench of the nonvolatile byte access controller
`timescale 1ns/100ps
module tb_top;
    localparam int TICKS = 20;
    localparam int DIV = 2;
    localparam int BUSY_CYC = TICKS * DIV;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, PWR_ARST_N = 1'b0;
    logic [5:0] IO_ADDR = 6'h00;
    logic [7:0] IO_WDATA = 8'h00;
    logic IO_WE = 1'b0, IO_RE = 1'b0, GLOBAL_IRQ_EN = 1'b0;
    logic FLASH_PROG_BUSY = 1'b0, POWER_DOWN = 1'b0;
    logic [7:0] IO_RDATA;
    logic CPU_STALL, EE_READY_IRQ, OSC_RUN_REQ;
    int num_errors = 0, n_compared = 0, cyc = 0, t0, n;
    logic [7:0] d;

    eebac_top #(.WRITE_TICKS(TICKS), .OSC_DIV(DIV)) uut (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
        .PWR_ARST_N(PWR_ARST_N), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WE(IO_WE),
        .IO_RE(IO_RE), .IO_RDATA(IO_RDATA), .CPU_STALL(CPU_STALL),
        .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .EE_READY_IRQ(EE_READY_IRQ),
        .FLASH_PROG_BUSY(FLASH_PROG_BUSY), .POWER_DOWN(POWER_DOWN), .OSC_RUN_REQ(OSC_RUN_REQ));

    always #2.5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) cyc <= cyc + 1;

    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %b expected %b", $time, g, e);
        end
    endtask
    // each access is taken at the second edge of the task
    task wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge CORE_CLK);
        IO_ADDR <= a; IO_WDATA <= v; IO_WE <= 1'b1;
        @(posedge CORE_CLK);
        IO_WE <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge CORE_CLK);
        IO_ADDR <= a; IO_RE <= 1'b1;
        @(posedge CORE_CLK);
        IO_RE <= 1'b0;
        #1 v = IO_RDATA;
    endtask
    task stall_len(output int k);
        #1 k = 0;
        while (CPU_STALL === 1'b1 && k < 20) begin
            k++;
            @(posedge CORE_CLK);
            #1;
        end
    endtask
    task wait_idle;
        int k;
        k = 0;
        d = 8'h02;
        while (d[1] !== 1'b0 && k < 40) begin
            rd(6'h1C, d);
            k++;
        end
        chk1(d[1], 1'b0);
    endtask

    task t_regs;
        rd(6'h1C, d); chk(d, 8'h00);
        wr(6'h1F, 8'h07); rd(6'h1F, d); chk(d, 8'h07);
        wr(6'h00, 8'hAA); rd(6'h00, d); chk(d, 8'h00);
        $display("test regs done");
    endtask
    task t_write;
        wait_idle;
        wr(6'h1F, 8'h05); wr(6'h1E, 8'hA5); wr(6'h1D, 8'hC3);
        wr(6'h1C, 8'h0C); rd(6'h1C, d); chk(d, 8'h0C);
        wr(6'h1C, 8'h0A); t0 = cyc; stall_len(n); chk(8'(n), 8'h02);
        @(posedge CORE_CLK) GLOBAL_IRQ_EN <= 1'b1;
        rd(6'h1C, d); chk(d, 8'h0A);
        chk1(EE_READY_IRQ, 1'b0);
        wr(6'h1E, 8'h00); wr(6'h1C, 8'h09); stall_len(n); chk(8'(n), 8'h00);
        while (cyc < t0 + BUSY_CYC - 4) @(posedge CORE_CLK);
        rd(6'h1C, d); chk1(d[1], 1'b1);
        while (cyc < t0 + BUSY_CYC + 2) @(posedge CORE_CLK);
        rd(6'h1C, d); chk1(d[1], 1'b0);
        chk1(EE_READY_IRQ, 1'b1);
        wr(6'h1D, 8'h00); wr(6'h1C, 8'h09); stall_len(n); chk(8'(n), 8'h04);
        rd(6'h1D, d); chk(d, 8'hC3);
        chk1(EE_READY_IRQ, 1'b1);
        @(posedge CORE_CLK) GLOBAL_IRQ_EN <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        chk1(EE_READY_IRQ, 1'b0);
        $display("test write done");
    endtask
    task t_guard;
        wr(6'h1C, 8'h04); repeat (4) @(posedge CORE_CLK);
        wr(6'h1C, 8'h02); rd(6'h1C, d); chk(d, 8'h00);
        wr(6'h1C, 8'h06); rd(6'h1C, d); chk(d, 8'h04);
        @(posedge CORE_CLK) FLASH_PROG_BUSY <= 1'b1;
        wr(6'h1C, 8'h04); wr(6'h1C, 8'h02); stall_len(n); chk(8'(n), 8'h00);
        rd(6'h1C, d); chk(d, 8'h00);
        @(posedge CORE_CLK) FLASH_PROG_BUSY <= 1'b0;
        $display("test guard done");
    endtask
    task t_reset_mid;
        wr(6'h1F, 8'h07); wr(6'h1E, 8'hFF); wr(6'h1D, 8'h5A);
        wr(6'h1C, 8'h04); wr(6'h1C, 8'h02);
        POWER_DOWN <= 1'b1;
        @(posedge CORE_CLK) ARST_N <= 1'b0;
        @(posedge CORE_CLK) ARST_N <= 1'b1;
        @(posedge CORE_CLK);
        chk1(OSC_RUN_REQ, 1'b1);
        rd(6'h1C, d); chk(d, 8'h02);
        wait_idle;
        repeat (2) @(posedge CORE_CLK);
        chk1(OSC_RUN_REQ, 1'b0);
        POWER_DOWN <= 1'b0;
        wr(6'h1F, 8'h07); wr(6'h1E, 8'hFF); wr(6'h1C, 8'h01);
        rd(6'h1D, d); chk(d, 8'h5A);
        wr(6'h1F, 8'h05); wr(6'h1E, 8'hA5); wr(6'h1C, 8'h01);
        rd(6'h1D, d); chk(d, 8'hC3);
        $display("test reset during write done");
    endtask

    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        PWR_ARST_N <= 1'b1;
        t_regs;
        t_write;
        t_guard;
        t_reset_mid;
        test_done;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #50000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end
endmodule // tb_top
